// ===== icx_map.svh
// Address map, bit positions, reset values and vector address of the interrupt control block
`ifndef ICX_MAP_SVH
`define ICX_MAP_SVH

`define ICX_AW                12
`define ICX_OFS_W             7
`define ICX_CTRL_OFS          7'h0b
`define ICX_PEN_ADDR          12'h091
`define ICX_SHD_BASE          12'hfe4
`define ICX_SHD_LAST          12'hfeb
`define ICX_SHD_N             8
`define ICX_SHD_IW            3

`define ICX_BIT_GLOBAL_EN     7
`define ICX_BIT_PERIPH_GATE   6
`define ICX_BIT_TIMER0_EN     5
`define ICX_BIT_PIN_EN        4
`define ICX_BIT_CHANGE_EN     3
`define ICX_BIT_TIMER0_FLAG   2
`define ICX_BIT_PIN_FLAG      1
`define ICX_BIT_CHANGE_FLAG   0

`define ICX_ST_TIMEOUT        4
`define ICX_ST_POWERDOWN      3

`define ICX_PC_W              15
`define ICX_VECTOR            15'h0004
`define ICX_CTRL_RST          8'h00
`define ICX_PEN_RST           8'h00
`define ICX_SHD_RST       8'h00
`define ICX_RDATA_RST     8'h00

`endif

// ===== icx_pkg.sv
// Types shared by the interrupt control block and its shadow store
package icx_pkg;

  typedef logic [7:0] icx_byte_t;

  // Lowest byte is shadow entry 0, highest is entry 7
  typedef struct packed {
    icx_byte_t ptr1_hi;
    icx_byte_t ptr1_lo;
    icx_byte_t ptr0_hi;
    icx_byte_t ptr0_lo;
    icx_byte_t pc_high_latch;
    icx_byte_t bank_select;
    icx_byte_t status;
    icx_byte_t w;
  } icx_ctx_t;

  typedef enum logic [1:0] {
    ICX_RUN = 2'b01,
    ICX_ISR = 2'b10
  } icx_state_t;

endpackage : icx_pkg

// ===== icx_shadow_if.sv
// Carrier between the interrupt controller and its shadow register store
`timescale 1ns/1ps
interface icx_shadow_if;
  logic             save;
  icx_pkg::icx_ctx_t save_ctx;
  logic             wr;
  logic [2:0]       idx;
  logic [7:0]       wdata;
  icx_pkg::icx_ctx_t q;

  modport ctrl  (output save, output save_ctx, output wr, output idx, output wdata, input q);
  modport store (input save, input save_ctx, input wr, input idx, input wdata, output q);
endinterface : icx_shadow_if

// ===== icx_shadow_store.sv
// Shadow register store: eight context bytes saved on entry, software accessible
`timescale 1ns/1ps
`include "icx_map.svh"
module icx_shadow_store (
  input wire logic     ref_clk,
  input wire logic     sys_rst,
  icx_shadow_if.store  sh
);

  logic [8*`ICX_SHD_N-1:0] save_flat;
  logic [8*`ICX_SHD_N-1:0] q_flat;

  assign save_flat = sh.save_ctx;
  assign sh.q      = q_flat;

  genvar gi;
  generate
    for (gi = 0; gi < `ICX_SHD_N; gi++) begin : g_entry
      logic [7:0] entry_reg;
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          entry_reg <= `ICX_SHD_RST;
        end else if (sh.save) begin
          entry_reg <= save_flat[8*gi +: 8];
        end else if (sh.wr && (int'(sh.idx) == gi)) begin
          entry_reg <= sh.wdata;
        end
      end
      assign q_flat[8*gi +: 8] = entry_reg;
    end
  endgenerate

endmodule : icx_shadow_store

// ===== icx_top.sv
// Interrupt control, peripheral enable gating and automatic context save/restore
`timescale 1ns/1ps
`include "icx_map.svh"

// Operation
// - Edge interrupt on pin, enabled by bit4
// - Edge select: one rising, zero falling
// - Valid edge sets pin flag bit1
// - Pin flag with both enables diverts execution
// - Entry pushes return address on stack
// - Entry copies context into shadow registers
// - Exit reloads live registers from shadows
// - Shadows readable, writable in bank 31
// - Global enable bit7 passes or blocks all
// - Bit6 gates every peripheral interrupt
// - Timer0 overflow sets bit2, bit5 enables
// - Bit3 permits the change interrupt
// - Change flag read-only, follows port flags
// - Flags set regardless of any enable
// - Peripheral enables: eight sources, bit7 down
// - Take flushes, clears global, vectors 0004h
// - Return pops, restores, sets global enable
module icx_top (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ext_irq_pin,
  input  wire logic                  ext_edge_select,
  input  wire logic                  timer0_overflow,
  input  wire logic [7:0]            port_change_flags,
  input  wire logic [7:0]            periph_irq_flags,
  input  wire logic [`ICX_PC_W-1:0]  cpu_return_pc,
  input  wire logic                  return_from_isr,
  input  wire logic [7:0]            live_w,
  input  wire logic [7:0]            live_status,
  input  wire logic [7:0]            live_bank_select,
  input  wire logic [7:0]            live_pc_high_latch,
  input  wire logic [15:0]           live_indirect_pointer0,
  input  wire logic [15:0]           live_indirect_pointer1,
  input  wire logic [`ICX_AW-1:0]    reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  output logic                       irq_take,
  output logic [`ICX_PC_W-1:0]       irq_vector,
  output logic                       stack_push,
  output logic [`ICX_PC_W-1:0]       stack_push_data,
  output logic                       stack_pop,
  output logic                       ctx_restore,
  output logic [7:0]                 restore_w,
  output logic [7:0]                 restore_status,
  output logic [7:0]                 restore_bank_select,
  output logic [7:0]                 restore_pc_high_latch,
  output logic [15:0]                restore_indirect_pointer0,
  output logic [15:0]                restore_indirect_pointer1
);

  localparam logic [7:0] CTRL_RST = `ICX_CTRL_RST;
  logic [7:0]          interrupt_control;
  logic                glob_en_reg;
  logic                gate_reg;
  logic                t0_en_reg;
  logic                pin_en_reg;
  logic                chg_en_reg;
  logic                t0_flag_reg;
  logic                pin_flag_reg;
  logic                chg_flag_reg;
  logic [7:0]          periph_enable_reg;
  logic                pin_s1_reg;
  logic                pin_s2_reg;
  logic                pin_s3_reg;
  logic                pin_rise;
  logic                pin_fall;
  logic                pin_edge;
  logic                ctrl_wr;
  logic                periph_enable_wr;
  logic                shd_hit;
  logic                change_any;
  logic                src_timer0;
  logic                src_ext;
  logic                src_change;
  logic                src_periph;
  logic                pending;
  logic                take_now;
  icx_pkg::icx_state_t state_reg;
  icx_pkg::icx_state_t state_next;
  logic [7:0]          rdata_next;
  logic [7:0]          status_saved;
  icx_pkg::icx_ctx_t   live_ctx;
  logic [`ICX_AW-1:0]  shd_ofs;

  icx_shadow_if sh ();

  icx_shadow_store u_store (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .sh      (sh)
  );

  // Pin synchroniser and edge detector
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= ext_irq_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign pin_rise = pin_s2_reg & ~pin_s3_reg;
  assign pin_fall = ~pin_s2_reg & pin_s3_reg;
  assign pin_edge = ext_edge_select ? pin_rise : pin_fall;

  // Register decode
  assign ctrl_wr          = reg_wr && (reg_addr[`ICX_OFS_W-1:0] == `ICX_CTRL_OFS);
  assign periph_enable_wr = reg_wr && (reg_addr == `ICX_PEN_ADDR);
  assign shd_hit   = (reg_addr >= `ICX_SHD_BASE) && (reg_addr <= `ICX_SHD_LAST);
  assign shd_ofs   = reg_addr - `ICX_SHD_BASE;

  assign change_any = |port_change_flags;

  // Source qualification
  assign src_timer0 = t0_en_reg & t0_flag_reg;
  assign src_ext    = pin_en_reg & pin_flag_reg;
  assign src_change = chg_en_reg & chg_flag_reg;
  assign src_periph = gate_reg & (|(periph_enable_reg & periph_irq_flags));

  assign pending = glob_en_reg &
                   (src_timer0 | src_ext | src_change | src_periph);

  // A return in the same cycle goes first; the pending source is taken next
  assign take_now = pending && !return_from_isr && !irq_take;

  // Control word as software reads it
  always_comb begin
    interrupt_control                       = '0;
    interrupt_control[`ICX_BIT_GLOBAL_EN]   = glob_en_reg;
    interrupt_control[`ICX_BIT_PERIPH_GATE] = gate_reg;
    interrupt_control[`ICX_BIT_TIMER0_EN]   = t0_en_reg;
    interrupt_control[`ICX_BIT_PIN_EN]      = pin_en_reg;
    interrupt_control[`ICX_BIT_CHANGE_EN]   = chg_en_reg;
    interrupt_control[`ICX_BIT_TIMER0_FLAG] = t0_flag_reg;
    interrupt_control[`ICX_BIT_PIN_FLAG]    = pin_flag_reg;
    interrupt_control[`ICX_BIT_CHANGE_FLAG] = chg_flag_reg;
  end

  // Interrupt control register, one concern per bit group
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      glob_en_reg <= CTRL_RST[`ICX_BIT_GLOBAL_EN];
    end else if (return_from_isr) begin
      glob_en_reg <= 1'b1;
    end else if (take_now) begin
      glob_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      glob_en_reg <= reg_wdata[`ICX_BIT_GLOBAL_EN];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gate_reg   <= CTRL_RST[`ICX_BIT_PERIPH_GATE];
      t0_en_reg  <= CTRL_RST[`ICX_BIT_TIMER0_EN];
      pin_en_reg <= CTRL_RST[`ICX_BIT_PIN_EN];
      chg_en_reg <= CTRL_RST[`ICX_BIT_CHANGE_EN];
    end else if (ctrl_wr) begin
      gate_reg   <= reg_wdata[`ICX_BIT_PERIPH_GATE];
      t0_en_reg  <= reg_wdata[`ICX_BIT_TIMER0_EN];
      pin_en_reg <= reg_wdata[`ICX_BIT_PIN_EN];
      chg_en_reg <= reg_wdata[`ICX_BIT_CHANGE_EN];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      t0_flag_reg <= CTRL_RST[`ICX_BIT_TIMER0_FLAG];
    end else if (timer0_overflow) begin
      t0_flag_reg <= 1'b1;
    end else if (ctrl_wr) begin
      t0_flag_reg <= reg_wdata[`ICX_BIT_TIMER0_FLAG];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_flag_reg <= CTRL_RST[`ICX_BIT_PIN_FLAG];
    end else if (pin_edge) begin
      pin_flag_reg <= 1'b1;
    end else if (ctrl_wr) begin
      pin_flag_reg <= reg_wdata[`ICX_BIT_PIN_FLAG];
    end
  end

  // Change flag follows the port flags and ignores writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chg_flag_reg <= CTRL_RST[`ICX_BIT_CHANGE_FLAG];
    end else begin
      chg_flag_reg <= change_any;
    end
  end

  // Peripheral enable register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      periph_enable_reg <= `ICX_PEN_RST;
    end else if (periph_enable_wr) begin
      periph_enable_reg <= reg_wdata;
    end
  end

  // Service state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      icx_pkg::ICX_RUN: begin
        if (take_now) begin
          state_next = icx_pkg::ICX_ISR;
        end
      end
      icx_pkg::ICX_ISR: begin
        if (return_from_isr) begin
          state_next = icx_pkg::ICX_RUN;
        end
      end
      default: begin
        state_next = icx_pkg::ICX_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= icx_pkg::ICX_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Entry: flush and vector, push, save context
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_take        <= 1'b0;
      irq_vector      <= `ICX_VECTOR;
      stack_push      <= 1'b0;
      stack_push_data <= '0;
    end else begin
      irq_take   <= take_now;
      irq_vector <= `ICX_VECTOR;
      stack_push <= take_now;
      if (take_now) begin
        stack_push_data <= cpu_return_pc;
      end
    end
  end

  // Timeout and power-down bits are not part of the saved context
  always_comb begin
    status_saved = live_status;
    status_saved[`ICX_ST_TIMEOUT]   = 1'b0;
    status_saved[`ICX_ST_POWERDOWN] = 1'b0;
  end

  always_comb begin
    live_ctx.w             = live_w;
    live_ctx.status        = status_saved;
    live_ctx.bank_select   = live_bank_select;
    live_ctx.pc_high_latch = live_pc_high_latch;
    live_ctx.ptr0_lo       = live_indirect_pointer0[7:0];
    live_ctx.ptr0_hi       = live_indirect_pointer0[15:8];
    live_ctx.ptr1_lo       = live_indirect_pointer1[7:0];
    live_ctx.ptr1_hi       = live_indirect_pointer1[15:8];
  end

  assign sh.save     = take_now;
  assign sh.save_ctx = live_ctx;
  assign sh.wr       = reg_wr && shd_hit;
  assign sh.idx      = shd_ofs[`ICX_SHD_IW-1:0];
  assign sh.wdata    = reg_wdata;

  // Exit: pop and restore from the shadow copies
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stack_pop                 <= 1'b0;
      ctx_restore               <= 1'b0;
      restore_w                 <= `ICX_SHD_RST;
      restore_status            <= `ICX_SHD_RST;
      restore_bank_select       <= `ICX_SHD_RST;
      restore_pc_high_latch     <= `ICX_SHD_RST;
      restore_indirect_pointer0 <= '0;
      restore_indirect_pointer1 <= '0;
    end else begin
      stack_pop   <= return_from_isr;
      ctx_restore <= return_from_isr;
      if (return_from_isr) begin
        restore_w                 <= sh.q.w;
        restore_status            <= sh.q.status;
        restore_status[`ICX_ST_TIMEOUT]   <= live_status[`ICX_ST_TIMEOUT];
        restore_status[`ICX_ST_POWERDOWN] <= live_status[`ICX_ST_POWERDOWN];
        restore_bank_select       <= sh.q.bank_select;
        restore_pc_high_latch     <= sh.q.pc_high_latch;
        restore_indirect_pointer0 <= {sh.q.ptr0_hi, sh.q.ptr0_lo};
        restore_indirect_pointer1 <= {sh.q.ptr1_hi, sh.q.ptr1_lo};
      end
    end
  end

  // Read port
  always_comb begin
    rdata_next = `ICX_RDATA_RST;
    if (reg_addr[`ICX_OFS_W-1:0] == `ICX_CTRL_OFS) begin
      rdata_next = interrupt_control;
    end else if (reg_addr == `ICX_PEN_ADDR) begin
      rdata_next = periph_enable_reg;
    end else if (shd_hit) begin
      rdata_next = sh.q[8*shd_ofs[`ICX_SHD_IW-1:0] +: 8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= `ICX_RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= `ICX_RDATA_RST;
    end
  end

endmodule : icx_top

// ===== icx_properties.sv
// Port-level assertions on the interrupt control block, bound to its top module
`timescale 1ns/1ps
`include "icx_map.svh"
module icx_chk (
  input wire logic                 ref_clk,
  input wire logic                 sys_rst,
  input wire logic [`ICX_PC_W-1:0] cpu_return_pc,
  input wire logic                 return_from_isr,
  input wire logic                 irq_take,
  input wire logic [`ICX_PC_W-1:0] irq_vector,
  input wire logic                 stack_push,
  input wire logic [`ICX_PC_W-1:0] stack_push_data,
  input wire logic                 stack_pop,
  input wire logic                 ctx_restore,
  input wire logic [7:0]           restore_w
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_restore;
    stack_pop && ctx_restore ##1 !stack_pop;
  endsequence
  sequence s_take;
    irq_take && stack_push;
  endsequence

  property p_ret;
    return_from_isr |=> s_restore;
  endproperty
  a_ret: assert property (p_ret) else $error("no restore after return");
  property p_pop;
    ctx_restore |-> stack_pop && $past(return_from_isr);
  endproperty
  a_pop: assert property (p_pop) else $error("restore without return");
  property p_push;
    irq_take |-> s_take and stack_push_data == $past(cpu_return_pc);
  endproperty
  a_push: assert property (p_push) else $error("bad push on take");
  property p_push_only;
    stack_push |-> irq_take;
  endproperty
  a_push_only: assert property (p_push_only) else $error("push without take");
  property p_vec;
    irq_vector == `ICX_VECTOR;
  endproperty
  a_vec: assert property (p_vec) else $error("vector not 0004");
  property p_take_once;
    irq_take |=> !irq_take;
  endproperty
  a_take_once: assert property (p_take_once) else $error("take not a pulse");
  property p_ret_first;
    return_from_isr |=> !irq_take;
  endproperty
  a_ret_first: assert property (p_ret_first) else $error("take beside return");
  property p_hold;
    !ctx_restore |-> $stable(restore_w);
  endproperty
  a_hold: assert property (p_hold) else $error("restore value moved");
endmodule : icx_chk

bind icx_top icx_chk u_chk (.ref_clk, .sys_rst, .cpu_return_pc, .return_from_isr, .irq_take,
  .irq_vector, .stack_push, .stack_push_data, .stack_pop, .ctx_restore, .restore_w);

// ===== icx_cpu_model.sv
// Behavioural CPU core holding the live context and program counter
`timescale 1ns/1ps
`include "icx_map.svh"
module icx_cpu_model (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ld,
  input  wire icx_pkg::icx_ctx_t     ld_ctx,
  input  wire logic                  irq_take,
  input  wire logic [`ICX_PC_W-1:0]  irq_vector,
  input  wire logic                  ctx_restore,
  input  wire icx_pkg::icx_ctx_t     rst_ctx,
  output icx_pkg::icx_ctx_t          ctx,
  output logic [`ICX_PC_W-1:0]       pc
);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctx <= '0;
    end else if (ld) begin
      ctx <= ld_ctx;
    end else if (ctx_restore) begin
      ctx <= rst_ctx;
    end else if (irq_take) begin
      ctx <= ~ctx; // Service routine overwrites every live register
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc <= '0;
    end else if (irq_take) begin
      pc <= irq_vector;
    end else begin
      pc <= pc + 1'b1;
    end
  end
endmodule : icx_cpu_model

// ===== tb.sv
// Self-checking bench for the interrupt control block
`timescale 1ns/1ps
`include "icx_map.svh"
module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_irq_pin = 1'b0;
  logic ext_edge_select = 1'b1;
  logic timer0_overflow = 1'b0;
  logic return_from_isr = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ld = 1'b0;
  logic [7:0] port_change_flags = 8'h00;
  logic [7:0] periph_irq_flags = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [`ICX_AW-1:0] reg_addr = '0;
  logic [63:0] sh = 64'h8877_6655_4433_2711;
  icx_pkg::icx_ctx_t cx = 64'h8877_6655_4433_2f11;
  icx_pkg::icx_ctx_t live;
  logic [`ICX_PC_W-1:0] cpu_return_pc, irq_vector, stack_push_data;
  logic [7:0] reg_rdata, restore_w, restore_status, restore_bank_select, restore_pc_high_latch;
  logic [15:0] restore_indirect_pointer0, restore_indirect_pointer1;
  logic irq_take, stack_push, stack_pop, ctx_restore;
  int error_cnt = 0;
  int check_count = 0;
  int takes = 0;
  int mark = 0;

  icx_top DUT (.ref_clk, .sys_rst, .ext_irq_pin, .ext_edge_select, .timer0_overflow,
    .port_change_flags, .periph_irq_flags, .cpu_return_pc, .return_from_isr,
    .live_w(live.w), .live_status(live.status), .live_bank_select(live.bank_select),
    .live_pc_high_latch(live.pc_high_latch), .live_indirect_pointer0({live.ptr0_hi, live.ptr0_lo}),
    .live_indirect_pointer1({live.ptr1_hi, live.ptr1_lo}), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq_take, .irq_vector, .stack_push, .stack_push_data, .stack_pop,
    .ctx_restore, .restore_w, .restore_status, .restore_bank_select, .restore_pc_high_latch,
    .restore_indirect_pointer0, .restore_indirect_pointer1);
  icx_cpu_model u_cpu (.ref_clk, .sys_rst, .ld, .ld_ctx(cx), .irq_take, .irq_vector,
    .ctx_restore, .rst_ctx({restore_indirect_pointer1, restore_indirect_pointer0,
    restore_pc_high_latch, restore_bank_select, restore_status, restore_w}),
    .ctx(live), .pc(cpu_return_pc));

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (irq_take === 1'b1) takes++;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask : rd
  task automatic pin(input logic v);
    @(posedge ref_clk) ext_irq_pin <= v;
    repeat (5) @(posedge ref_clk);
  endtask : pin
  task automatic exp_takes(input int n);
    repeat (8) @(posedge ref_clk);
    chk("irq_take count", takes - mark, n);
    mark = takes;
  endtask : exp_takes
  task automatic ret;
    @(posedge ref_clk) return_from_isr <= 1'b1;
    @(posedge ref_clk) return_from_isr <= 1'b0;
    #1 chk("ctx_restore", ctx_restore, 1'b1);
  endtask : ret
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(12'h00b, 8'h00);
    rd(12'h091, 8'h00);
    wr(12'h091, 8'hff);
    rd(12'h091, 8'hff);
    rd(12'hfec, 8'h00);
    wr(12'h091, 8'h00);
    @(posedge ref_clk) port_change_flags <= 8'h04;
    rd(12'h00b, 8'h01);
    wr(12'h00b, 8'h00);
    rd(12'h00b, 8'h01);
    @(posedge ref_clk) port_change_flags <= 8'h00;
    rd(12'h00b, 8'h00);
    @(posedge ref_clk) timer0_overflow <= 1'b1;
    @(posedge ref_clk) timer0_overflow <= 1'b0;
    rd(12'h00b, 8'h04);
    wr(12'h00b, 8'h24);
    exp_takes(0);
    wr(12'h00b, 8'ha4);
    exp_takes(1);
    rd(12'h00b, 8'h24);
    wr(12'h00b, 8'h20);
    ret();
    rd(12'h00b, 8'ha0);
    wr(12'h00b, 8'h00);
    pin(1'b1);
    rd(12'h00b, 8'h02);
    wr(12'h00b, 8'h00);
    pin(1'b0);
    rd(12'h00b, 8'h00);
    @(posedge ref_clk) ext_edge_select <= 1'b0;
    pin(1'b1);
    rd(12'h00b, 8'h00);
    pin(1'b0);
    rd(12'h00b, 8'h02);
    wr(12'h00b, 8'h00);
    @(posedge ref_clk) ld <= 1'b1;
    @(posedge ref_clk) ld <= 1'b0;
    ext_edge_select <= 1'b1;
    wr(12'h00b, 8'h90);
    pin(1'b1);
    exp_takes(1);
    rd(12'h00b, 8'h12);
    for (int i = 0; i < 8; i++) rd(12'hfe4 + 12'(i), sh[8*i+:8]);
    wr(12'hfe4, 8'h5a);
    rd(12'hfe4, 8'h5a);
    wr(12'h00b, 8'h10);
    ret();
    chk("restore_w", restore_w, 8'h5a);
    chk("restore_status", restore_status, 8'h37);
    chk("restore_bank_select", restore_bank_select, 8'h33);
    chk("restore_pc_high_latch", restore_pc_high_latch, 8'h44);
    chk("restore_indirect_pointer0", restore_indirect_pointer0, 16'h6655);
    chk("restore_indirect_pointer1", restore_indirect_pointer1, 16'h8877);
    rd(12'h00b, 8'h90);
    @(posedge ref_clk) port_change_flags <= 8'h80;
    wr(12'h00b, 8'h80);
    exp_takes(0);
    wr(12'h00b, 8'h88);
    exp_takes(1);
    @(posedge ref_clk) port_change_flags <= 8'h00;
    ret();
    for (int i = 0; i < 8; i++) begin
      wr(12'h00b, 8'h00);
      wr(12'h091, 8'h01 << i);
      @(posedge ref_clk) periph_irq_flags <= 8'h01 << i;
      wr(12'h00b, 8'h80);
      exp_takes(0);
      wr(12'h00b, 8'hc0);
      exp_takes(1);
      @(posedge ref_clk) periph_irq_flags <= 8'h00;
      ret();
    end
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(12'h00b, 8'h00);
    rd(12'h091, 8'h00);
    finish_test();
  end
endmodule : tb
